// [hw/ueec_regs.vh]
// constants shared by the serial unit and its receiver
// assumes one 20 MHz operating clock
`ifndef UEEC_REGS_VH
`define UEEC_REGS_VH

// parity select codes {high, low}
`define UEEC_PAR_NONE 2'h0
`define UEEC_PAR_ZERO 2'h1
`define UEEC_PAR_ODD 2'h2
`define UEEC_PAR_EVEN 2'h3

// error status bit positions
`define UEEC_ST_PARITY 2
`define UEEC_ST_FRAMING 1
`define UEEC_ST_OVERRUN 0
`define UEEC_ST_RESET 3'h0

// oversampling: 16 ticks a bit, start checked at tick 7
`define UEEC_OVS_LAST 4'hF
`define UEEC_OVS_MID 4'h7

// extra operating clocks between frames in continuous transmission
`define UEEC_CONT_GAP_CLKS 2'h2

// reset values
`define UEEC_TXBUF_RESET 8'h00
`define UEEC_RXBUF_RESET 8'hFF
`define UEEC_DIV_RESET 8'h00

`endif

// [hw/ueec_rx.v]
// receiver of the serial unit: start detect, data, parity, one stop bit
// assumes a 16x oversampling enable pulse from the top module
`timescale 1ns/1ns
`include "ueec_regs.vh"

module ueec_rx (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// control
	input wire enable,
	input wire ovs_en,
	input wire char8,
	input wire [1:0] parity_mode,
	// line
	input wire rxd,
	// result
	output reg done,
	output reg [7:0] data,
	output reg parity_err,
	output reg framing_err
);

	localparam S_IDLE = 3'h0;
	localparam S_START = 3'h1;
	localparam S_DATA = 3'h2;
	localparam S_PAR = 3'h3;
	localparam S_STOP = 3'h4;

	reg [2:0] state_reg;
	reg [3:0] tick_reg;
	reg [2:0] bit_reg;
	reg [7:0] shift_reg;
	reg par_reg;
	wire [7:0] word = char8 ? shift_reg : {1'b0, shift_reg[7:1]};
	wire odd_ones = ^word ^ par_reg;
	wire sample = ovs_en && (tick_reg == `UEEC_OVS_LAST);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= S_IDLE;
			tick_reg <= 4'h0;
			bit_reg <= 3'h0;
			shift_reg <= 8'h00;
			par_reg <= 1'b0;
			done <= 1'b0;
			data <= `UEEC_RXBUF_RESET;
			parity_err <= 1'b0;
			framing_err <= 1'b0;
		end else begin
			done <= 1'b0;
			if (ovs_en)
				tick_reg <= tick_reg + 4'h1;
			if (!enable) begin
				state_reg <= S_IDLE;
			end else begin
				case (state_reg)
				S_IDLE: begin
					// a low level, not an edge, starts reception
					if (!rxd) begin
						state_reg <= S_START;
						tick_reg <= 4'h0;
					end
				end
				S_START: begin
					if (ovs_en && tick_reg == `UEEC_OVS_MID) begin
						tick_reg <= 4'h0;
						bit_reg <= 3'h0;
						state_reg <= rxd ? S_IDLE : S_DATA;
					end
				end
				S_DATA: begin
					if (sample) begin
						shift_reg <= {rxd, shift_reg[7:1]};
						bit_reg <= bit_reg + 3'h1;
						if (bit_reg == (char8 ? 3'h7 : 3'h6))
							state_reg <= (parity_mode == `UEEC_PAR_NONE) ? S_STOP : S_PAR;
					end
				end
				S_PAR: begin
					if (sample) begin
						par_reg <= rxd;
						state_reg <= S_STOP;
					end
				end
				S_STOP: begin
					// only the first stop position is checked
					if (sample) begin
						done <= 1'b1;
						data <= word;
						framing_err <= ~rxd;
						parity_err <= (parity_mode == `UEEC_PAR_ODD) ? ~odd_ones :
							(parity_mode == `UEEC_PAR_EVEN) ? odd_ones : 1'b0;
						state_reg <= S_IDLE;
					end
				end
				default: state_reg <= S_IDLE;
				endcase
			end
		end
	end

endmodule

// [hw/ueec_top.v]
// serial transmit/receive unit with enable ordering and error control
// assumes control bits arrive as plain ports synchronous to CLOCK
//
// Overview of operation
// - enabling reception with the input low starts a reception at once.
// - receiver always expects one stop bit; stop length affects transmit only.
// - parity error flag follows the configured parity mode.
// - framing error checks only the first stop bit position.
// - on overrun the new character is dropped, buffer kept.
// - reading error status inserts one wait cycle before data.
// - a write while the buffer full flag is high overwrites the pending byte.
// - continuous transmission adds two operating clocks between frames.
`timescale 1ns/1ns
`include "ueec_regs.vh"

module ueec_top (
	// clock and reset
	input wire CLOCK,
	input wire RSTN,
	// control bits
	input wire UNIT_POWER_ENABLE,
	input wire TRANSMIT_ENABLE_BIT,
	input wire RECEIVE_ENABLE_BIT,
	input wire PARITY_SELECT_HIGH,
	input wire PARITY_SELECT_LOW,
	input wire CHAR_LENGTH_8,
	input wire STOP_LENGTH_SELECT,
	input wire ERROR_INTERRUPT_ROUTING,
	input wire [7:0] BAUD_DIVISOR,
	// transmit buffer
	input wire TX_WRITE,
	input wire [7:0] TRANSMIT_BUFFER,
	output wire TX_BUFFER_FULL_FLAG,
	output wire TX_SHIFT_BUSY_FLAG,
	output reg TX_COMPLETE_IRQ,
	// receive buffer
	input wire RX_BUFFER_READ,
	output reg [7:0] RECEIVE_BUFFER,
	output reg RX_COMPLETE_IRQ,
	output reg RX_ERROR_IRQ,
	// error status read
	input wire ERR_READ_REQ,
	output reg ERR_READ_WAIT,
	output reg ERR_READ_ACK,
	output reg [2:0] RX_ERROR_STATUS_REG,
	// serial line
	input wire SERIAL_RECEIVE_INPUT,
	output reg SERIAL_TRANSMIT_OUTPUT
);

	localparam T_IDLE = 3'h0;
	localparam T_START = 3'h1;
	localparam T_DATA = 3'h2;
	localparam T_PAR = 3'h3;
	localparam T_STOP = 3'h4;
	localparam T_GAP = 3'h5;

	// parity bit to send for a word in a given mode
	function par_bit;
		input [1:0] mode;
		input [7:0] word;
		begin
			case (mode)
			`UEEC_PAR_ODD: par_bit = ~^word;
			`UEEC_PAR_EVEN: par_bit = ^word;
			default: par_bit = 1'b0;
			endcase
		end
	endfunction

	wire [1:0] parity_mode = {PARITY_SELECT_HIGH, PARITY_SELECT_LOW};
	wire tx_on = UNIT_POWER_ENABLE & TRANSMIT_ENABLE_BIT;
	wire rx_on = UNIT_POWER_ENABLE & RECEIVE_ENABLE_BIT;

	//****************************************
	// oversampling divider
	//****************************************
	reg [7:0] div_reg;
	reg ovs_en;

	always @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			div_reg <= `UEEC_DIV_RESET;
			ovs_en <= 1'b0;
		end else if (!UNIT_POWER_ENABLE) begin
			div_reg <= `UEEC_DIV_RESET;
			ovs_en <= 1'b0;
		end else begin
			ovs_en <= (div_reg == 8'h00);
			div_reg <= (div_reg == 8'h00) ? BAUD_DIVISOR : div_reg - 8'h01;
		end
	end

	//****************************************
	// transmitter
	//****************************************
	reg [2:0] tstate_reg;
	reg [3:0] ttick_reg;
	reg [2:0] tbit_reg;
	reg [7:0] tshift_reg;
	reg [7:0] tbuf_reg;
	reg tfull_reg;
	reg tpar_reg;
	reg stop2_reg;
	reg [1:0] gap_reg;
	wire tbit_end = ovs_en && (ttick_reg == `UEEC_OVS_LAST);
	wire tload = tfull_reg && (tstate_reg == T_IDLE || (tstate_reg == T_GAP && gap_reg == 2'h1));
	wire [7:0] tword = CHAR_LENGTH_8 ? tbuf_reg : {1'b0, tbuf_reg[6:0]};

	assign TX_BUFFER_FULL_FLAG = tfull_reg;
	assign TX_SHIFT_BUSY_FLAG = (tstate_reg != T_IDLE);

	always @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			tstate_reg <= T_IDLE;
			ttick_reg <= 4'h0;
			tbit_reg <= 3'h0;
			tshift_reg <= 8'h00;
			tbuf_reg <= `UEEC_TXBUF_RESET;
			tfull_reg <= 1'b0;
			tpar_reg <= 1'b0;
			stop2_reg <= 1'b0;
			gap_reg <= 2'h0;
			TX_COMPLETE_IRQ <= 1'b0;
			SERIAL_TRANSMIT_OUTPUT <= 1'b1;
		end else if (!tx_on) begin
			tstate_reg <= T_IDLE;
			tfull_reg <= 1'b0;
			TX_COMPLETE_IRQ <= 1'b0;
			SERIAL_TRANSMIT_OUTPUT <= 1'b1;
		end else begin
			TX_COMPLETE_IRQ <= 1'b0;
			if (ovs_en)
				ttick_reg <= ttick_reg + 4'h1;
			// a write while full overwrites the pending byte
			if (TX_WRITE) begin
				tbuf_reg <= TRANSMIT_BUFFER;
				tfull_reg <= 1'b1;
			end else if (tload) begin
				tfull_reg <= 1'b0;
			end
			if (tload) begin
				tshift_reg <= tword;
				tpar_reg <= par_bit(parity_mode, tword);
				tstate_reg <= T_START;
				ttick_reg <= 4'h0;
				SERIAL_TRANSMIT_OUTPUT <= 1'b0;
			end else begin
				case (tstate_reg)
				T_IDLE: SERIAL_TRANSMIT_OUTPUT <= 1'b1;
				T_START: begin
					if (tbit_end) begin
						tstate_reg <= T_DATA;
						tbit_reg <= 3'h0;
						SERIAL_TRANSMIT_OUTPUT <= tshift_reg[0];
						tshift_reg <= {1'b0, tshift_reg[7:1]};
					end
				end
				T_DATA: begin
					if (tbit_end) begin
						tbit_reg <= tbit_reg + 3'h1;
						if (tbit_reg == (CHAR_LENGTH_8 ? 3'h7 : 3'h6)) begin
							stop2_reg <= STOP_LENGTH_SELECT;
							if (parity_mode == `UEEC_PAR_NONE) begin
								tstate_reg <= T_STOP;
								SERIAL_TRANSMIT_OUTPUT <= 1'b1;
							end else begin
								tstate_reg <= T_PAR;
								SERIAL_TRANSMIT_OUTPUT <= tpar_reg;
							end
						end else begin
							SERIAL_TRANSMIT_OUTPUT <= tshift_reg[0];
							tshift_reg <= {1'b0, tshift_reg[7:1]};
						end
					end
				end
				T_PAR: begin
					if (tbit_end) begin
						tstate_reg <= T_STOP;
						SERIAL_TRANSMIT_OUTPUT <= 1'b1;
					end
				end
				T_STOP: begin
					if (tbit_end) begin
						if (stop2_reg) begin
							stop2_reg <= 1'b0;
						end else if (tfull_reg) begin
							tstate_reg <= T_GAP;
							gap_reg <= `UEEC_CONT_GAP_CLKS;
						end else begin
							tstate_reg <= T_IDLE;
							TX_COMPLETE_IRQ <= 1'b1;
						end
					end
				end
				T_GAP: gap_reg <= gap_reg - 2'h1;
				default: tstate_reg <= T_IDLE;
				endcase
			end
		end
	end

	//****************************************
	// receiver, buffer and error flags
	//****************************************
	wire rx_done;
	wire [7:0] rx_data;
	wire rx_perr;
	wire rx_ferr;
	reg rfull_reg;
	reg [2:0] status_reg;
	reg [2:0] status_next;
	wire overrun = rx_done && rfull_reg && !RX_BUFFER_READ;
	wire any_err = rx_done && (rx_perr || rx_ferr || overrun);

	ueec_rx u_rx (
		.clk(CLOCK),
		.rst_n(RSTN),
		.enable(rx_on),
		.ovs_en(ovs_en),
		.char8(CHAR_LENGTH_8),
		.parity_mode(parity_mode),
		.rxd(SERIAL_RECEIVE_INPUT),
		.done(rx_done),
		.data(rx_data),
		.parity_err(rx_perr),
		.framing_err(rx_ferr)
	);

	// read clears the flags; a new error in the same cycle wins
	always @* begin
		status_next = ERR_READ_WAIT ? `UEEC_ST_RESET : status_reg;
		if (rx_done) begin
			status_next[`UEEC_ST_PARITY] = status_next[`UEEC_ST_PARITY] | rx_perr;
			status_next[`UEEC_ST_FRAMING] = status_next[`UEEC_ST_FRAMING] | rx_ferr;
			status_next[`UEEC_ST_OVERRUN] = status_next[`UEEC_ST_OVERRUN] | overrun;
		end
	end

	always @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			rfull_reg <= 1'b0;
			status_reg <= `UEEC_ST_RESET;
			RECEIVE_BUFFER <= `UEEC_RXBUF_RESET;
			RX_COMPLETE_IRQ <= 1'b0;
			RX_ERROR_IRQ <= 1'b0;
			ERR_READ_WAIT <= 1'b0;
			ERR_READ_ACK <= 1'b0;
			RX_ERROR_STATUS_REG <= `UEEC_ST_RESET;
		end else if (!UNIT_POWER_ENABLE) begin
			rfull_reg <= 1'b0;
			status_reg <= `UEEC_ST_RESET;
			RX_COMPLETE_IRQ <= 1'b0;
			RX_ERROR_IRQ <= 1'b0;
			ERR_READ_WAIT <= 1'b0;
			ERR_READ_ACK <= 1'b0;
		end else begin
			status_reg <= status_next;
			// overrun drops the character and keeps the buffer
			if (rx_done && !overrun) begin
				RECEIVE_BUFFER <= rx_data;
				rfull_reg <= 1'b1;
			end else if (RX_BUFFER_READ) begin
				rfull_reg <= 1'b0;
			end
			RX_COMPLETE_IRQ <= rx_done && (!any_err || ERROR_INTERRUPT_ROUTING);
			RX_ERROR_IRQ <= any_err && !ERROR_INTERRUPT_ROUTING;
			// one wait cycle, then data with acknowledge
			ERR_READ_WAIT <= ERR_READ_REQ && !ERR_READ_WAIT && !ERR_READ_ACK;
			ERR_READ_ACK <= ERR_READ_WAIT;
			if (ERR_READ_WAIT)
				RX_ERROR_STATUS_REG <= status_reg;
		end
	end

endmodule

// [bench/ueec_props.sv]
// checker on the ports of the serial unit
// assumes binding into ueec_top, one clock domain
`timescale 1ns/1ns
module ueec_props (
	// clock and reset
	input wire CLOCK,
	input wire RSTN,
	// watched ports
	input wire UNIT_POWER_ENABLE,
	input wire TRANSMIT_ENABLE_BIT,
	input wire TX_WRITE,
	input wire TX_BUFFER_FULL_FLAG,
	input wire TX_SHIFT_BUSY_FLAG,
	input wire TX_COMPLETE_IRQ,
	input wire ERR_READ_REQ,
	input wire ERR_READ_WAIT,
	input wire ERR_READ_ACK,
	input wire SERIAL_TRANSMIT_OUTPUT
);
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RSTN);
	wire tx_on = UNIT_POWER_ENABLE && TRANSMIT_ENABLE_BIT;
	a_err_read_wait: assert property (ERR_READ_REQ && UNIT_POWER_ENABLE && !ERR_READ_WAIT &&
		!ERR_READ_ACK |=> ERR_READ_WAIT ##1 ERR_READ_ACK) else $error("no wait before ack");
	a_wait_one_cycle: assert property (ERR_READ_WAIT |=> !ERR_READ_WAIT)
		else $error("wait too long");
	a_ack_single: assert property (ERR_READ_ACK |=> !ERR_READ_ACK && !ERR_READ_WAIT)
		else $error("ack not a pulse");
	a_full_on_write: assert property (TX_WRITE && tx_on |=> TX_BUFFER_FULL_FLAG)
		else $error("full not set");
	a_full_moves_out: assert property ($rose(TX_BUFFER_FULL_FLAG) && !TX_SHIFT_BUSY_FLAG &&
		tx_on |=> !TX_BUFFER_FULL_FLAG && TX_SHIFT_BUSY_FLAG) else $error("byte not moved");
	a_idle_line_high: assert property (!TX_SHIFT_BUSY_FLAG |-> SERIAL_TRANSMIT_OUTPUT)
		else $error("line low while idle");
	a_start_bit_low: assert property ($rose(TX_SHIFT_BUSY_FLAG) |-> !SERIAL_TRANSMIT_OUTPUT)
		else $error("no start bit");
	a_done_when_empty: assert property (TX_COMPLETE_IRQ |-> !TX_BUFFER_FULL_FLAG
		##1 !TX_COMPLETE_IRQ) else $error("completion with byte pending");
	a_write_while_off: assert property (TX_WRITE && !tx_on && !TX_BUFFER_FULL_FLAG
		|=> !TX_BUFFER_FULL_FLAG) else $error("write accepted while off");
endmodule
bind ueec_top ueec_props ueec_props_inst (.*);

// [bench/ueec_node.sv]
// remote serial node: drives the receive line, decodes the transmit line
// assumes 16 clocks a bit, 8 data bits, no parity on the transmit side
`timescale 1ns/1ns
module ueec_node (
	// clock
	input wire logic clk,
	// line
	input wire logic txd,
	output logic rxd
);
	logic [7:0] got_q[$];
	int t_q[$];
	int cyc = 0;
	logic [7:0] d;
	initial rxd = 1'b1;
	always @(posedge clk) cyc <= cyc + 1;
	// lsb first; last bit may be cut short
	task send(input logic [10:0] f, input int n, input int last);
		for (int i = 0; i < n; i++) begin
			rxd <= f[i];
			repeat ((i == n - 1) ? last : 16) @(posedge clk);
		end
		rxd <= 1'b1;
	endtask
	// a low stop bit shows as inverted data
	always begin
		@(negedge txd);
		t_q.push_back(cyc);
		repeat (8) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (16) @(posedge clk);
			d[i] = txd;
		end
		repeat (16) @(posedge clk);
		got_q.push_back(txd ? d : ~d);
	end
endmodule

// [bench/uart_enable_and_error_control_test.sv]
// self-checking bench for the serial unit
// assumes ueec_top, ueec_node and the bound checker
`timescale 1ns/1ns
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin failures++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module uart_enable_and_error_control_test;
	logic CLOCK = 0, RSTN = 0, pw = 0, te = 0, re = 0, ph = 0, pl = 0, sl = 0;
	logic txw = 0, rdr = 0, erq = 0, unread = 0, cl = 1, ir = 0;
	logic [7:0] tbuf = 8'h00, b1, b2, exp_buf = 8'hFF;
	logic [2:0] exp_st = 3'h0;
	wire full, busy, tirq, rirq, eirq, ack, rxd, txd;
	wire [7:0] rbuf;
	wire [2:0] st;
	int failures = 0, check_count = 0, ntirq = 0;
	ueec_top ueec_top_inst (.CLOCK(CLOCK), .RSTN(RSTN), .UNIT_POWER_ENABLE(pw),
		.TRANSMIT_ENABLE_BIT(te), .RECEIVE_ENABLE_BIT(re), .PARITY_SELECT_HIGH(ph),
		.PARITY_SELECT_LOW(pl), .CHAR_LENGTH_8(cl), .STOP_LENGTH_SELECT(sl),
		.ERROR_INTERRUPT_ROUTING(ir), .BAUD_DIVISOR(8'h00), .TX_WRITE(txw),
		.TRANSMIT_BUFFER(tbuf), .TX_BUFFER_FULL_FLAG(full), .TX_SHIFT_BUSY_FLAG(busy),
		.TX_COMPLETE_IRQ(tirq), .RX_BUFFER_READ(rdr), .RECEIVE_BUFFER(rbuf),
		.RX_COMPLETE_IRQ(rirq), .RX_ERROR_IRQ(eirq), .ERR_READ_REQ(erq), .ERR_READ_WAIT(),
		.ERR_READ_ACK(ack), .RX_ERROR_STATUS_REG(st), .SERIAL_RECEIVE_INPUT(rxd),
		.SERIAL_TRANSMIT_OUTPUT(txd));
	ueec_node ueec_node_inst (.clk(CLOCK), .txd(txd), .rxd(rxd));
	initial forever #25 CLOCK = ~CLOCK;
	always @(posedge CLOCK) if (tirq === 1'b1) ntirq++;
	// ****
	// tasks
	// ****
	task stop_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	function logic sig(int k);
		case (k)
			0: return !full;
			1: return tirq;
			2: return rirq | eirq;
			default: return ack;
		endcase
	endfunction
	task waitfor(input int k);
		int n;
		n = 0;
		do begin
			@(posedge CLOCK) #1;
			if (++n > 2000) begin
				failures++;
				stop_test;
			end
		end while (sig(k) !== 1'b1);
	endtask
	task txb(input logic [7:0] v);
		@(posedge CLOCK) begin
			txw <= 1'b1;
			tbuf <= v;
		end
		@(posedge CLOCK) txw <= 1'b0;
		#1 `CHK("full after write", te, full)
	endtask
	task rdb;
		@(posedge CLOCK) rdr <= 1'b1;
		@(posedge CLOCK) rdr <= 1'b0;
		unread = 0;
	endtask
	task errrd;
		@(posedge CLOCK) erq <= 1'b1;
		waitfor(3);
		`CHK("status", exp_st, st)
		erq <= 1'b0;
		exp_st = 3'h0;
	endtask
	task setmode(input logic [1:0] m, input logic c, input logic r);
		@(posedge CLOCK) begin
			te <= 1'b0;
			re <= 1'b0;
		end
		@(posedge CLOCK) begin
			{ph, pl} <= m;
			cl <= c;
			ir <= r;
			sl <= 1'b1;
		end
		@(posedge CLOCK) begin
			te <= 1'b1;
			re <= 1'b1;
		end
	endtask
	task rxf(input logic [7:0] v, input logic bp, input logic bs, input logic rd);
		logic [1:0] m;
		logic [2:0] x;
		logic [7:0] w;
		logic [10:0] f;
		int k;
		logic p;
		logic e;
		logic r;
		m = {ph, pl};
		w = cl ? v : {1'b0, v[6:0]};
		p = ((m == 2'h3) ? ^w : (m == 2'h2) ? ~^w : 1'b0) ^ bp;
		// start, data lsb first, parity if any, one stop
		f = {2'h3, w, 1'b0};
		k = cl ? 9 : 8;
		if (m != 2'h0) begin
			f[k] = p;
			k++;
		end
		f[k] = ~bs;
		fork
			ueec_node_inst.send(f, k + 1, bs ? 10 : 16);
			begin
				waitfor(2);
				e = eirq;
				r = rirq;
			end
		join
		x = {bp && m[1], bs, unread};
		if (!unread) exp_buf = w;
		exp_st = exp_st | x;
		unread = 1;
		`CHK("error irq", (x != 3'h0) && !ir, e)
		`CHK("done irq", (x == 3'h0) || ir, r)
		`CHK("buffer", exp_buf, rbuf)
		if (rd) rdb;
	endtask
	// ****
	// sequence
	// ****
	initial begin
		void'($urandom(88));
		repeat (8) @(posedge CLOCK);
		RSTN <= 1'b1;
		@(posedge CLOCK) pw <= 1'b1;
		@(posedge CLOCK) te <= 1'b1;
		b1 = $urandom;
		b2 = $urandom;
		txb(b1);
		waitfor(0);
		`CHK("busy while shifting", 1'b1, busy)
		txb(b2);
		waitfor(1);
		`CHK("busy after done", 1'b0, busy)
		repeat (4) @(posedge CLOCK);
		`CHK("tx byte 1", b1, ueec_node_inst.got_q[0])
		`CHK("tx byte 2", b2, ueec_node_inst.got_q[1])
		`CHK("frame gap", 162, ueec_node_inst.t_q[1] - ueec_node_inst.t_q[0])
		`CHK("tx irqs", 1, ntirq)
		@(posedge CLOCK) te <= 1'b0;
		txb(8'h5A);
		fork
			ueec_node_inst.send({2'h3, 8'hF0, 1'b0}, 10, 16);
			begin
				repeat (2) @(posedge CLOCK);
				re <= 1'b1;
				waitfor(2);
			end
		join
		`CHK("enable on low line", 8'hF0, rbuf)
		rdb;
		for (int m = 0; m < 4; m++) begin
			setmode(m, 1'b1, 1'b0);
			rxf($urandom, 1'b0, 1'b0, 1'b1);
			rxf($urandom, 1'b1, 1'b0, 1'b1);
			errrd;
		end
		rxf($urandom, 1'b0, 1'b1, 1'b1);
		errrd;
		rxf($urandom, 1'b0, 1'b0, 1'b0);
		rxf($urandom, 1'b0, 1'b0, 1'b1);
		errrd;
		rxf($urandom, 1'b0, 1'b0, 1'b1);
		`CHK("no extra tx", 2, ueec_node_inst.got_q.size())
		setmode(2'h2, 1'b0, 1'b1);
		rxf($urandom, 1'b1, 1'b0, 1'b1);
		errrd;
		setmode(2'h0, 1'b1, 1'b0);
		txb(8'h3C);
		waitfor(0);
		txb(8'hC3);
		waitfor(1);
		repeat (4) @(posedge CLOCK);
		`CHK("tx byte 3", 8'h3C, ueec_node_inst.got_q[2])
		`CHK("tx byte 4", 8'hC3, ueec_node_inst.got_q[3])
		`CHK("two stop gap", 178, ueec_node_inst.t_q[3] - ueec_node_inst.t_q[2])
		`CHK("tx irqs", 2, ntirq)
		@(posedge CLOCK) begin
			te <= 1'b0;
			re <= 1'b0;
		end
		@(posedge CLOCK) pw <= 1'b0;
		stop_test;
	end
endmodule
